/* hdl/fbk_alu.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Computes one block result from its operands
module fbk_alu (
   fbk_exec_if.alu ex
);
   import fbk_pkg::*;
   logic signed [17:0] sum;
   logic signed [16:0] thresh;
   logic signed [15:0] sa;
   logic signed [15:0] sb;
   logic signed [15:0] sc;
   logic [15:0] wa;
   logic [15:0] wb;
   logic [15:0] wc;
   logic ba;
   logic bb;
   logic bc;

   always_comb begin
      // Unconnected operands take the neutral value of the operation
      sa = ex.conn[0] ? signed'(ex.op_a) : 16'sd0;
      sb = ex.conn[1] ? signed'(ex.op_b) : 16'sd0;
      sc = ex.conn[2] ? signed'(ex.op_c) : 16'sd0;
      ba = ex.conn[0] ? ex.op_a[0] : 1'b1;
      bb = ex.conn[1] ? ex.op_b[0] : 1'b1;
      bc = ex.conn[2] ? ex.op_c[0] : 1'b1;
      wa = ex.conn[0] ? ex.op_a : WORD_FALSE;
      wb = ex.conn[1] ? ex.op_b : WORD_FALSE;
      wc = ex.conn[2] ? ex.op_c : WORD_TRUE;
      sum = 18'(sa) + 18'(sb) + 18'(sc);
      thresh = 17'(sb) - 17'(sc);
      ex.hyst_out = ex.hyst_in;
      ex.result = WORD_FALSE;
      case (ex.func)
         FBK_FN_ADD: begin
            if (sum > 18'sd32767) begin
               ex.result = WORD_MAX;
            end else if (sum < -18'sd32768) begin
               ex.result = WORD_MIN;
            end else begin
               ex.result = sum[15:0];
            end
         end
         FBK_FN_AND: begin
            ex.result = (ba && bb && bc) ? WORD_TRUE : WORD_FALSE;
         end
         FBK_FN_BITWISE: begin
            ex.result = (wa | wb) & wc;
         end
         FBK_FN_BSET: begin
            // Missing or out-of-range bit number leaves the word unchanged
            ex.result = wa;
            if (ex.conn[1] && ex.conn[2] && ex.op_b <= 16'd15) begin
               ex.result[ex.op_b[3:0]] = ex.op_c[0];
            end
         end
         FBK_FN_COMPARE: begin
            if (sa > sb) begin
               ex.hyst_out = 1'b1;
            end else if (17'(sa) < thresh) begin
               ex.hyst_out = 1'b0;
            end
            ex.result[CMP_GT_BIT] = sa > sb;
            ex.result[CMP_EQ_BIT] = sa == sb;
            ex.result[CMP_LT_BIT] = sa < sb;
            ex.result[CMP_HYST_BIT] = ex.hyst_out;
         end
         default: begin
            ex.result = WORD_FALSE;
         end
      endcase
   end
endmodule : fbk_alu
`default_nettype wire

/* hdl/fbk_exec_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Carries one block's fetched operands to the arithmetic core and back
interface fbk_exec_if;
   import fbk_pkg::*;
   logic [WORD_W-1:0] op_a;
   logic [WORD_W-1:0] op_b;
   logic [WORD_W-1:0] op_c;
   logic [NUM_OPERANDS-1:0] conn;
   fbk_func_t func;
   logic hyst_in;
   logic [WORD_W-1:0] result;
   logic hyst_out;
   modport core (output op_a, op_b, op_c, conn, func, hyst_in,
                 input result, hyst_out);
   modport alu (input op_a, op_b, op_c, conn, func, hyst_in,
                output result, hyst_out);
endinterface : fbk_exec_if
`default_nettype wire

/* hdl/fbk_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Resolves one operand selector into a value
module fbk_fetch (
   input wire logic [15:0] sel,
   input wire logic is_const,
   input wire logic [3:0] bitsel,
   input wire logic as_bool,
   input wire logic logic_inv,
   input wire logic [fbk_pkg::NUM_SOURCES-1:0][15:0] sources,
   output logic [15:0] value,
   output logic connected
);
   import fbk_pkg::*;
   logic [15:0] mag;
   logic [15:0] raw;
   logic [15:0] inv;

   always_comb begin
      mag = sel[15] ? 16'(-sel) : sel;
      raw = 16'h0000;
      connected = 1'b0;
      if (is_const) begin
         raw = sel;
         connected = 1'b1;
      end else if (mag != 16'h0000 && mag <= 16'(NUM_SOURCES)) begin
         raw = sources[mag - 16'h0001];
         connected = 1'b1;
      end
      // Word operands invert bitwise, integers negate
      inv = raw;
      if (!is_const && sel[15]) begin
         inv = logic_inv ? ~raw : 16'(-raw);
      end
      value = inv;
      if (as_bool) begin
         // Constants give true as 1, so a constant uses bit 0
         value = {15'h0000, is_const ? inv[0] : inv[bitsel]};
      end
   end
endmodule : fbk_fetch
`default_nettype wire

/* hdl/fbk_pkg.sv */
// ==========================================================================
// Shared constants for the function block array
package fbk_pkg;
   localparam int NUM_BLOCKS = 16;
   localparam int NUM_PARAMS = 16;
   localparam int WORD_W = 16;
   localparam int NUM_OPERANDS = 3;
   localparam int NUM_SOURCES = NUM_BLOCKS + NUM_PARAMS;
   localparam int APB_AW = 12;

   typedef enum logic [2:0] {
      FBK_FN_NONE,
      FBK_FN_ADD,
      FBK_FN_AND,
      FBK_FN_BITWISE,
      FBK_FN_BSET,
      FBK_FN_COMPARE
   } fbk_func_t;

   // ========================================================================
   // Register map: one 32-byte window per block, then globals
   localparam logic [APB_AW-1:0] BLK_STRIDE = 12'h020;
   localparam logic [2:0] REG_SEL_A = 3'h0;
   localparam logic [2:0] REG_SEL_B = 3'h1;
   localparam logic [2:0] REG_SEL_C = 3'h2;
   localparam logic [2:0] REG_ATTRIB = 3'h3;
   localparam logic [2:0] REG_FUNC = 3'h4;
   localparam logic [2:0] REG_OUT_PTR = 3'h5;
   localparam logic [2:0] REG_RESULT = 3'h6;
   localparam logic [APB_AW-1:0] CTRL_ADDR = 12'h200;
   localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h204;
   localparam int CTRL_RUN_BIT = 0;
   localparam int STATUS_RUN_BIT = 8;
   localparam int STATUS_ROUND_LSB = 16;

   // ========================================================================
   // Attribute word fields
   localparam int ATTR_BITSEL_LSB = 0;
   localparam int ATTR_BITSEL_W = 4;
   localparam int ATTR_CONST_LSB = 12;
   localparam logic [15:0] ATTRIB_RESET = 16'h0000;
   localparam logic [15:0] SEL_RESET = 16'h0000;

   // ========================================================================
   // Result encodings
   localparam logic [15:0] WORD_TRUE = 16'hffff;
   localparam logic [15:0] WORD_FALSE = 16'h0000;
   localparam logic [15:0] WORD_MAX = 16'h7fff;
   localparam logic [15:0] WORD_MIN = 16'h8000;
   localparam int CMP_GT_BIT = 0;
   localparam int CMP_EQ_BIT = 1;
   localparam int CMP_LT_BIT = 2;
   localparam int CMP_HYST_BIT = 3;
endpackage : fbk_pkg

/* hdl/fbk_top.sv */
// ==========
//Contract
// - Sixteen blocks, three operands, one result each
// - Boolean operand: one true, zero false
// - Attribute word: constant flags and bit selects
// - Results are sources; pointer writes destination
// - Add mode sums three signed operands
// - AND true only if all connected true
// - AND false all zeros, true all ones
// - Bitwise: (a OR b) AND c per bit
// - Bit-set replaces bit b of a by c
// - Compare flags: greater, equal, less bits
// - Hysteresis bit sets above, clears below b-c
// - Compare result bits above three stay zero
// - Compare treats operands as signed integers
// - Operands sampled when each block executes
// - Negative selector inverts the fetched value
// - Unconnected operand takes the neutral value
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fbk_top #(
   parameter int NUM_BLOCKS = fbk_pkg::NUM_BLOCKS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fbk_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Parameter sources and pointer writes
   input wire logic [fbk_pkg::NUM_PARAMS-1:0][15:0] fw_param_in,
   output logic param_wr_valid,
   output logic [15:0] param_wr_addr,
   output logic [15:0] param_wr_data
);
   import fbk_pkg::*;

   // ========================================================================
   // Elaboration check
   // Index and decode are four bits wide, and the sources
   // list exactly sixteen block results before the parameters
   if (NUM_BLOCKS != fbk_pkg::NUM_BLOCKS) begin : g_bad_count
      $error("fbk_top: block count must match the source map");
   end

   // Block windows end below the global registers
   if (NUM_BLOCKS * int'(BLK_STRIDE) > int'(CTRL_ADDR)) begin : g_bad_map
      $error("fbk_top: block windows overlap the global registers");
   end

   // Bit selects, then one constant flag per operand
   if (ATTR_CONST_LSB + NUM_OPERANDS > WORD_W
       || NUM_OPERANDS * ATTR_BITSEL_W > ATTR_CONST_LSB) begin : g_bad_attr
      $error("fbk_top: attribute fields overlap or overflow");
   end

   // ========================================================================
   // Block configuration and state
   // Written only from the bus
   logic [15:0] sel_reg [NUM_BLOCKS][NUM_OPERANDS];
   logic [15:0] attrib [NUM_BLOCKS];
   fbk_func_t func_reg [NUM_BLOCKS];
   logic [15:0] out_ptr [NUM_BLOCKS];

   // Written only by execution
   logic [15:0] result [NUM_BLOCKS];
   logic [NUM_BLOCKS-1:0] hyst;

   // Sequencing
   logic run;
   logic [3:0] cur;
   logic [15:0] round_cnt;

   // Operand path of the running block
   logic [NUM_SOURCES-1:0][15:0] src_bus;
   logic [NUM_OPERANDS-1:0][15:0] op_val;
   logic [NUM_OPERANDS-1:0] op_conn;
   logic [NUM_OPERANDS-1:0] as_bool;
   logic [NUM_OPERANDS-1:0] logic_inv;

   fbk_exec_if ex ();

   // ========================================================================
   // APB decode
   // Fields of the current transfer
   logic setup;
   logic access;
   logic in_blk;
   logic is_ctrl;
   logic is_status;
   logic [3:0] a_blk;
   logic [2:0] a_reg;
   logic a_valid;
   logic a_ro;

   assign setup = psel && !penable;
   assign access = psel && penable;

   // No wait states
   assign pready = 1'b1;

   // Block in bits 8:5, register in bits 4:2
   assign a_blk = paddr[8:5];
   assign a_reg = paddr[4:2];
   assign in_blk = paddr < 12'(NUM_BLOCKS * BLK_STRIDE);
   assign is_ctrl = paddr == CTRL_ADDR;
   assign is_status = paddr == STATUS_ADDR;

   // Misaligned or unmapped: error, no effect
   assign a_valid = (paddr[1:0] == 2'b00)
                    && ((in_blk && a_reg <= REG_RESULT) || is_ctrl
                        || is_status);
   assign a_ro = (in_blk && a_reg == REG_RESULT) || is_status;

   // Read data and error are captured in setup so they come from flops;
   // a result that updates during the access shows its older value.
   // Only setup cycles load them, so they stand through the access.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !a_valid || (pwrite && a_ro);
         prdata <= 32'h0000_0000;
         if (!pwrite && a_valid) begin
            if (is_ctrl) begin
               prdata[CTRL_RUN_BIT] <= run;
            end else if (is_status) begin
               prdata[3:0] <= cur;
               prdata[STATUS_RUN_BIT] <= run;
               prdata[STATUS_ROUND_LSB +: 16] <= round_cnt;
            end else begin
               case (a_reg)
                  REG_SEL_A: prdata[15:0] <= sel_reg[a_blk][0];
                  REG_SEL_B: prdata[15:0] <= sel_reg[a_blk][1];
                  REG_SEL_C: prdata[15:0] <= sel_reg[a_blk][2];
                  REG_ATTRIB: prdata[15:0] <= attrib[a_blk];
                  REG_FUNC: prdata[2:0] <= func_reg[a_blk];
                  REG_OUT_PTR: prdata[15:0] <= out_ptr[a_blk];
                  REG_RESULT: prdata[15:0] <= result[a_blk];
                  default: prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // ========================================================================
   // Configuration writes
   // Taken at the access edge; a block running in that same cycle
   // still uses the old value and sees the new one next round.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         run <= 1'b0;
         for (int i = 0; i < NUM_BLOCKS; i++) begin
            for (int j = 0; j < NUM_OPERANDS; j++) begin
               sel_reg[i][j] <= SEL_RESET;
            end
            attrib[i] <= ATTRIB_RESET;
            func_reg[i] <= FBK_FN_NONE;
            out_ptr[i] <= 16'h0000;
         end
      end else if (access && pwrite && a_valid && !a_ro) begin
         if (is_ctrl) begin
            run <= pwdata[CTRL_RUN_BIT];
         end else begin
            case (a_reg)
               REG_SEL_A: sel_reg[a_blk][0] <= pwdata[15:0];
               REG_SEL_B: sel_reg[a_blk][1] <= pwdata[15:0];
               REG_SEL_C: sel_reg[a_blk][2] <= pwdata[15:0];
               REG_ATTRIB: attrib[a_blk] <= pwdata[15:0];
               REG_FUNC: begin
                  // Unknown codes fall back to an idle block
                  if (pwdata[2:0] <= 3'(FBK_FN_COMPARE)) begin
                     func_reg[a_blk] <= fbk_func_t'(pwdata[2:0]);
                  end else begin
                     func_reg[a_blk] <= FBK_FN_NONE;
                  end
               end
               REG_OUT_PTR: out_ptr[a_blk] <= pwdata[15:0];
               default: run <= run;
            endcase
         end
      end
   end

   // ========================================================================
   // Source map: block outputs first, then firmware parameters
   // Selector n picks entry n-1; zero means unconnected.
   // Results first, so a block reads earlier blocks of this round.
   for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_src
      if (i < NUM_BLOCKS) begin : g_blk
         assign src_bus[i] = result[i];
      end else begin : g_par
         assign src_bus[i] = fw_param_in[i - NUM_BLOCKS];
      end
   end

   // ========================================================================
   // Operand fetch for the block now executing
   // Boolean use and inversion follow the running block
   always_comb begin
      as_bool = '0;
      logic_inv = '0;
      case (func_reg[cur])
         FBK_FN_AND: begin
            // All flags; negative selectors complement
            as_bool = 3'b111;
            logic_inv = 3'b111;
         end
         FBK_FN_BITWISE: begin
            // Whole words, complemented when negative
            logic_inv = 3'b111;
         end
         FBK_FN_BSET: begin
            // Bit number stays an integer and negates
            as_bool = 3'b100;
            logic_inv = 3'b101;
         end
         default: begin
            // Integer operands negate when negative
            as_bool = '0;
            logic_inv = '0;
         end
      endcase
   end

   // Operands are read as their block runs, never latched before
   for (genvar g = 0; g < NUM_OPERANDS; g++) begin : g_op
      fbk_fetch u_fetch (
         .sel(sel_reg[cur][g]),
         .is_const(attrib[cur][ATTR_CONST_LSB + g]),
         .bitsel(attrib[cur][ATTR_BITSEL_LSB + g*ATTR_BITSEL_W +:
                             ATTR_BITSEL_W]),
         .as_bool(as_bool[g]),
         .logic_inv(logic_inv[g]),
         .sources(src_bus),
         .value(op_val[g]),
         .connected(op_conn[g])
      );
   end

   // One shared core; it keeps no state of its own.
   // hyst_in is the running block's own crossing state.
   assign ex.op_a = op_val[0];
   assign ex.op_b = op_val[1];
   assign ex.op_c = op_val[2];
   assign ex.conn = op_conn;
   assign ex.func = func_reg[cur];
   assign ex.hyst_in = hyst[cur];

   fbk_alu u_alu (
      .ex(ex)
   );

   // ========================================================================
   // Execution: one block per cycle in index order, so a block sees the
   // new results of the blocks before it in the same round.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cur <= 4'h0;
         round_cnt <= 16'h0000;
         hyst <= '0;
         for (int i = 0; i < NUM_BLOCKS; i++) begin
            result[i] <= 16'h0000;
         end
      end else if (run) begin
         result[cur] <= ex.result;
         // Crossing state is kept per block
         hyst[cur] <= ex.hyst_out;
         cur <= cur + 4'h1;
         // The round count wraps; it is only a heartbeat
         if (cur == 4'(NUM_BLOCKS - 1)) begin
            round_cnt <= round_cnt + 16'h0001;
         end
      end
   end

   // ========================================================================
   // Output pointer writes
   // One pulse per run block with a pointer set. Targets that
   // do not exist are still signalled; the receiver ignores
   // them.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         param_wr_valid <= 1'b0;
         param_wr_addr <= 16'h0000;
         param_wr_data <= 16'h0000;
      end else begin
         param_wr_valid <= run && (out_ptr[cur] != 16'h0000);
         param_wr_addr <= out_ptr[cur];
         param_wr_data <= ex.result;
      end
   end
endmodule : fbk_top
`default_nettype wire

/* tb/fbk_param_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Firmware parameter store: 17..32 are writable destinations
module fbk_param_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic param_wr_valid,
   input wire logic [15:0] param_wr_addr,
   input wire logic [15:0] param_wr_data,
   output logic [fbk_pkg::NUM_PARAMS-1:0][15:0] fw_param_in
);
   import fbk_pkg::*;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_PARAMS; i++)
            fw_param_in[i] <= 16'h1234 + 16'(i);
      end else if (param_wr_valid && param_wr_addr >= 16'd17
                   && param_wr_addr <= 16'd32) begin
         fw_param_in[4'(param_wr_addr - 16'd17)] <= param_wr_data;
      end
   end
endmodule : fbk_param_model
`default_nettype wire

/* tb/fbk_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fbk_top_chk #(
   parameter int NUM_BLOCKS = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fbk_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [fbk_pkg::NUM_PARAMS-1:0][15:0] fw_param_in,
   input wire logic param_wr_valid,
   input wire logic [15:0] param_wr_addr,
   input wire logic [15:0] param_wr_data
);
   import fbk_pkg::*;
   localparam logic [11:0] BLK_END = 12'(NUM_BLOCKS * 32);
   logic setup;
   logic run_q;
   logic run_d;
   assign setup = psel && !penable;
   // ==========
   // Mirror of the run bit, one cycle late to match registered pulses
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         run_q <= 1'b0;
         run_d <= 1'b0;
      end else begin
         if (psel && penable && pwrite && paddr == CTRL_ADDR)
            run_q <= pwdata[CTRL_RUN_BIT];
         run_d <= run_q;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========
   // Properties
   property p_rst;
      disable iff (1'b0)
      !resetn |=> !param_wr_valid && !pslverr && prdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_ptr;
      param_wr_valid |-> param_wr_addr != 16'h0000;
   endproperty
   a_ptr: assert property (p_ptr) else $error("write with null ptr");
   property p_stop;
      !run_d |-> !param_wr_valid;
   endproperty
   a_stop: assert property (p_stop) else $error("exec while stopped");
   property p_unmap;
      setup && paddr > STATUS_ADDR |=> pslverr;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped accepted");
   property p_unal;
      setup && paddr[1:0] != 2'b00 |=> pslverr;
   endproperty
   a_unal: assert property (p_unal) else $error("unaligned accepted");
   property p_ro;
      setup && pwrite && paddr < BLK_END && paddr[4:2] == REG_RESULT
         |=> pslverr;
   endproperty
   a_ro: assert property (p_ro) else $error("result write accepted");
   property p_upper;
      setup && !pwrite && paddr < BLK_END |=> prdata[31:16] == 16'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper half set");
   property p_ok;
      setup && paddr < BLK_END && paddr[1:0] == 2'b00
         && paddr[4:2] < REG_RESULT |=> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("valid access refused");
   property p_hold;
      setup ##1 !setup |=> $stable(prdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule : fbk_top_chk
bind fbk_top fbk_top_chk #(.NUM_BLOCKS(NUM_BLOCKS)) fbk_top_chk_i (
   .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fw_param_in(fw_param_in),
   .param_wr_valid(param_wr_valid), .param_wr_addr(param_wr_addr),
   .param_wr_data(param_wr_data));
`default_nettype wire

/* tb/fbk_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fbk_top_tb;
   import fbk_pkg::*;
   typedef struct packed {
      fbk_func_t f;
      logic [15:0] a, b, c, at, exp;
   } fbk_row_t;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NUM_PARAMS-1:0][15:0] fw_param_in;
   logic param_wr_valid;
   logic [15:0] param_wr_addr;
   logic [15:0] param_wr_data;
   logic [31:0] rdv;
   logic err;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   fbk_row_t rows [0:18];

   always #2 ref_clk = ~ref_clk;

   fbk_top #(.NUM_BLOCKS(NUM_BLOCKS)) fbk_top_i (.ref_clk(ref_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fw_param_in(fw_param_in),
      .param_wr_valid(param_wr_valid), .param_wr_addr(param_wr_addr),
      .param_wr_data(param_wr_data));
   fbk_param_model fbk_param_model_i (.ref_clk(ref_clk), .resetn(resetn),
      .param_wr_valid(param_wr_valid), .param_wr_addr(param_wr_addr),
      .param_wr_data(param_wr_data), .fw_param_in(fw_param_in));

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : chk

   // ==========
   // APB master: released only after the edge that samples pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input string what);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp, what);
   endtask : rd

   function automatic logic [11:0] ad(input int b, input logic [2:0] r);
      return 12'(b * 32) + {7'h00, r, 2'b00};
   endfunction : ad

   // Waits two full rounds so chained blocks settle
   task automatic cfg(input int b, input fbk_func_t f, input logic [15:0] x,
                      input logic [15:0] y, input logic [15:0] z,
                      input logic [15:0] at);
      apb(1'b1, ad(b, REG_SEL_A), {16'h0, x});
      apb(1'b1, ad(b, REG_SEL_B), {16'h0, y});
      apb(1'b1, ad(b, REG_SEL_C), {16'h0, z});
      apb(1'b1, ad(b, REG_ATTRIB), {16'h0, at});
      apb(1'b1, ad(b, REG_FUNC), {29'h0, f});
      repeat (40) @(posedge ref_clk);
   endtask : cfg

   task automatic res(input int b, input logic [15:0] exp);
      rd(ad(b, REG_RESULT), {16'h0, exp}, "result");
   endtask : res

   task automatic row(input fbk_row_t r);
      cfg(0, r.f, r.a, r.b, r.c, r.at);
      res(0, r.exp);
   endtask : row

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      rows = '{
         '{FBK_FN_ADD, 16'h0064, 16'hffe2, 16'h0007, 16'h7000, 16'h004d},
         '{FBK_FN_ADD, 16'h7000, 16'h7000, 16'h0000, 16'h7000, 16'h7fff},
         '{FBK_FN_ADD, 16'h8000, 16'h8000, 16'h0000, 16'h7000, 16'h8000},
         '{FBK_FN_ADD, 16'h0005, 16'h0006, 16'h0021, 16'h3000, 16'h000b},
         '{FBK_FN_AND, 16'h0001, 16'h0001, 16'h0000, 16'h3000, 16'hffff},
         '{FBK_FN_AND, 16'h0011, 16'h0001, 16'h0001, 16'h6002, 16'hffff},
         '{FBK_FN_AND, 16'h0011, 16'h0001, 16'h0001, 16'h6003, 16'h0000},
         '{FBK_FN_BITWISE, 16'h00f0, 16'h0f00, 16'h3c3c, 16'h7000, 16'h0c30},
         '{FBK_FN_BITWISE, 16'hffef, 16'h0000, 16'hffff, 16'h6000, 16'hedcb},
         '{FBK_FN_BSET, 16'h00ff, 16'h000f, 16'h0001, 16'h7000, 16'h80ff},
         '{FBK_FN_BSET, 16'h00ff, 16'h0000, 16'h0000, 16'h7000, 16'h00fe},
         '{FBK_FN_BSET, 16'h00ff, 16'h0010, 16'h0001, 16'h7000, 16'h00ff},
         '{FBK_FN_COMPARE, 16'h0005, 16'h0003, 16'h0002, 16'h7000, 16'h0009},
         '{FBK_FN_COMPARE, 16'h0003, 16'h0003, 16'h0002, 16'h7000, 16'h000a},
         '{FBK_FN_COMPARE, 16'h0002, 16'h0003, 16'h0002, 16'h7000, 16'h000c},
         '{FBK_FN_COMPARE, 16'h0000, 16'h0003, 16'h0002, 16'h7000, 16'h0004},
         '{FBK_FN_COMPARE, 16'hffff, 16'h0001, 16'h0000, 16'h7000, 16'h0004},
         '{FBK_FN_COMPARE, 16'h0001, 16'hffff, 16'h0000, 16'h7000, 16'h0009},
         '{FBK_FN_NONE, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0}};
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      // ==========
      // Reset values, refused accesses and the run bit
      rd(ad(0, REG_SEL_A), 32'h0, "sel reset");
      rd(ad(15, REG_RESULT), 32'h0, "result reset");
      rd(STATUS_ADDR, 32'h0, "status reset");
      apb(1'b1, ad(2, REG_RESULT), 32'h5);
      chk({31'h0, err}, 32'h1, "result write");
      apb(1'b0, 12'h300, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      apb(1'b0, 12'h002, 32'h0);
      chk({31'h0, err}, 32'h1, "unaligned");
      apb(1'b1, ad(1, REG_FUNC), 32'h7);
      rd(ad(1, REG_FUNC), 32'h0, "bad func");
      apb(1'b1, CTRL_ADDR, 32'h1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk({31'h0, rdv[STATUS_RUN_BIT]}, 32'h1, "run");
      rd(CTRL_ADDR, 32'h1, "ctrl");
      chk({31'h0, pready}, 32'h1, "ready");
      $display("test registers done");
      // ==========
      // Operations on block 0
      for (int i = 0; i < 4; i++)
         row(rows[i]);
      for (int i = 0; i < 8; i++) begin
         cfg(0, FBK_FN_AND, 16'(i & 1), 16'((i >> 1) & 1),
             16'((i >> 2) & 1), 16'h7000);
         res(0, (i == 7) ? WORD_TRUE : WORD_FALSE);
      end
      for (int i = 4; i < 7; i++)
         row(rows[i]);
      for (int i = 7; i < 12; i++)
         row(rows[i]);
      for (int i = 12; i < 18; i++)
         row(rows[i]);
      res(1, 16'h0000);
      $display("test functions done");
      // ==========
      // Chaining, negated sources and output pointer
      cfg(2, FBK_FN_ADD, 16'h0001, 16'h0010, 16'h0000, 16'h2000);
      res(2, 16'h0019);
      apb(1'b1, ad(3, REG_OUT_PTR), 32'h12);
      cfg(3, FBK_FN_ADD, 16'hfffd, 16'h0000, 16'h0000, 16'h0000);
      res(3, 16'hffe7);
      cfg(4, FBK_FN_ADD, 16'h0012, 16'h0000, 16'h0000, 16'h0000);
      res(4, 16'hffe7);
      chk({16'h0, fw_param_in[1]}, 32'hffe7, "param write");
      $display("test chaining done");
      // ==========
      // Stopped execution freezes results
      apb(1'b1, CTRL_ADDR, 32'h0);
      apb(1'b1, ad(0, REG_SEL_A), 32'hffff);
      repeat (40) @(posedge ref_clk);
      res(0, 16'h0009);
      $display("test stop done");
      report_and_stop();
   end
endmodule : fbk_top_tb
`default_nettype wire
